// file: logic/predriver_reset_enable_control.v
`timescale 1ns/10ps
`default_nettype none
`include "predriver_defines.vh"

module predriver_reset_enable_control #(
    parameter CHANNELS = `CHANNELS,
    parameter RETRY_CYCLES = 32000
) (
    // clock and power-on reset
    input wire clk,
    input wire reset,
    input wire logic_supply,
    // host control pins
    input wire master_reset_n,
    input wire global_enable_n,
    input wire chip_select_n,
    // channel commands and fault detection
    input wire [CHANNELS-1:0] gate_cmd,
    input wire [CHANNELS-1:0] parallel_gate_in,
    input wire [CHANNELS-1:0] retry_mode,
    input wire [CHANNELS-1:0] fault_detect,
    // outputs
    output wire [CHANNELS-1:0] gate_drive_out,
    output wire [CHANNELS-1:0] fault_latched,
    output reg fault_flag_n_oe,
    output wire fault_flag_n_out,
    output reg serial_enable,
    output reg timer_clock_enable,
    output reg diag_enable,
    output reg clear_config,
    output reg send_revision,
    output reg ready
);

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    // power-up sequence, one pass per release of every reset source:
    //   reset  - held while the supply is low or master_reset_n is low;
    //            gates and enables low, clear_config and send_revision high, registers held at defaults
    //   init   - fixed count of cycles so the rest of the chip settles
    //            before the first command is obeyed
    //   run    - commands obeyed, serial port and fault flag live
    // a reset source seen in init or run drops straight back to reset.
    // the outputs do not wait for the state register: the merged live
    // term below takes the raw reset pins, so gates and enables drop at
    // the first edge that sees a pin low.
    reg [1:0] state;
    reg [1:0] next_state;
    reg [`INIT_CNT_W-1:0] init_cnt;
    wire any_reset;
    wire run;
    wire live;
    wire enabled;
    reg cs_prev;
    wire frame_end;

    // supply loss or external reset both hold the block in reset
    assign any_reset = !logic_supply || !master_reset_n;
    assign run = (state == `ST_RUN);

    // ----------------------------------------------------------------
    // merged reset and enable terms
    // ----------------------------------------------------------------
    // live: running and no reset pin asserted in this very cycle
    assign live = run && !any_reset;
    assign enabled = live && !global_enable_n;
    assign frame_end = !cs_prev && chip_select_n;
    assign fault_flag_n_out = 1'b0; // open drain only pulls low

    // next-state decode
    always @* begin
        next_state = state;
        case (state)
            `ST_RESET: begin
                if (!any_reset) begin
                    next_state = `ST_INIT;
                end
            end
            `ST_INIT: begin
                if (any_reset) begin
                    next_state = `ST_RESET;
                end else if (init_cnt == `INIT_CYCLES - 1) begin
                    next_state = `ST_RUN;
                end
            end
            `ST_RUN: begin
                if (any_reset) begin
                    next_state = `ST_RESET;
                end
            end
            default: begin
                next_state = `ST_RESET;
            end
        endcase
    end

    // state register and init counter
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= `ST_RESET;
            init_cnt <= {`INIT_CNT_W{1'b0}};
        end else begin
            state <= next_state;
            if (state == `ST_INIT) begin
                init_cnt <= init_cnt + 1'b1;
            end else begin
                init_cnt <= {`INIT_CNT_W{1'b0}};
            end
        end
    end

    // ----------------------------------------------------------------
    // enables to the rest of the chip
    // ----------------------------------------------------------------
    reg next_serial_enable;
    reg next_timer_clock_enable;
    reg next_diag_enable;
    reg next_clear_config;
    reg next_ready;

    // next levels: all follow the merged terms, so no output can lead
    // or trail the others by a cycle
    always @* begin
        next_serial_enable = live;
        next_timer_clock_enable = live;
        next_diag_enable = enabled;
        next_clear_config = !live;
        next_ready = live;
    end

    // registered so downstream blocks see clean levels
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            serial_enable <= 1'b0;
            timer_clock_enable <= 1'b0;
            diag_enable <= 1'b0;
            clear_config <= 1'b1;
            ready <= 1'b0;
        end else begin
            serial_enable <= next_serial_enable;
            timer_clock_enable <= next_timer_clock_enable;
            diag_enable <= next_diag_enable;
            clear_config <= next_clear_config;
            ready <= next_ready;
        end
    end

    // ----------------------------------------------------------------
    // revision-first response
    // ----------------------------------------------------------------
    // cleared only at the end of the first frame after reset
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            cs_prev <= 1'b1;
            send_revision <= 1'b1;
        end else begin
            cs_prev <= chip_select_n;
            if (!live) begin
                send_revision <= 1'b1;
            end else if (frame_end) begin
                send_revision <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // fault flag
    // ----------------------------------------------------------------
    // driven low while any fault latched and no frame in progress
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_flag_n_oe <= 1'b0;
        end else begin
            fault_flag_n_oe <= live && chip_select_n && (|fault_latched);
        end
    end

    // ----------------------------------------------------------------
    // global retry timer
    // ----------------------------------------------------------------
    // held at zero while disabled and free-running while enabled, so a retry waits up to one full period
    reg [31:0] retry_cnt;
    wire retry_tick;
    assign retry_tick = (retry_cnt == RETRY_CYCLES - 1);
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            retry_cnt <= 32'h0;
        end else if (!enabled || retry_tick) begin
            retry_cnt <= 32'h0;
        end else begin
            retry_cnt <= retry_cnt + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // per-channel gate logic
    // ----------------------------------------------------------------
    // one slice per channel; each sees the merged live and enabled terms,
    // so a reset pin clears shut-down and latch state at the same edge
    genvar i;
    generate
        for (i = 0; i < CHANNELS; i = i + 1) begin : chan
            channel_gate u_gate (
                .clk(clk),
                .reset(reset),
                .run(live),
                .enabled(enabled),
                .clear_status(!live),
                .cmd_on(gate_cmd[i] | parallel_gate_in[i]),
                .fault_in(fault_detect[i]),
                .retry_mode(retry_mode[i]),
                .retry_tick(retry_tick),
                .gate(gate_drive_out[i]),
                .fault_latched(fault_latched[i])
            );
        end
    endgenerate

endmodule // predriver_reset_enable_control

`default_nettype wire

// file: include/predriver_defines.vh
`ifndef PREDRIVER_DEFINES_VH
`define PREDRIVER_DEFINES_VH

// ----------------------------------------------------------------
// counts and timing
// ----------------------------------------------------------------
`define CHANNELS 6
`define CLK_PERIOD_NS 8
`define FRAME_GAP_NS 1600
`define FRAME_GAP_CYCLES ((`FRAME_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYCLES 16
`define INIT_CNT_W 5

// ----------------------------------------------------------------
// sequencer states
// ----------------------------------------------------------------
`define ST_RESET 2'h0
`define ST_INIT 2'h1
`define ST_RUN 2'h2

// ----------------------------------------------------------------
// register reset values
// ----------------------------------------------------------------
`define GATE_CMD_DEFAULT 6'h00
`define FAULT_LATCH_DEFAULT 6'h00

`endif

// file: logic/channel_gate.v
`timescale 1ns/10ps
`default_nettype none

module channel_gate (
    // clock and reset
    input wire clk,
    input wire reset,
    // control
    input wire run,
    input wire enabled,
    input wire clear_status,
    input wire cmd_on,
    input wire fault_in,
    input wire retry_mode,
    input wire retry_tick,
    // outputs
    output reg gate,
    output reg fault_latched
);

    // fault latch: kept while disabled, cleared by resets only
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            fault_latched <= 1'b0;
        end else if (enabled && fault_in) begin
            fault_latched <= 1'b1; // set wins over clear
        end else if (clear_status) begin
            fault_latched <= 1'b0;
        end
    end

    // shut-down flag; released by run low, enable low or a retry tick in retry mode
    reg shut;
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            shut <= 1'b0;
        end else if (!run) begin
            shut <= 1'b0;
        end else if (enabled && fault_in) begin
            shut <= 1'b1;
        end else if (!enabled || (retry_mode && retry_tick)) begin
            shut <= 1'b0;
        end
    end

    // registered gate drive
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            gate <= 1'b0;
        end else begin
            gate <= run && enabled && cmd_on && !shut && !fault_in;
        end
    end

endmodule // channel_gate

`default_nettype wire

// file: verif/predriver_reset_enable_control_properties.sv
`timescale 1ns/10ps
`default_nettype none
module reset_enable_checker #(parameter CHANNELS = 6, parameter RETRY_CYCLES = 20) (
    // clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic logic_supply,
    input wire logic master_reset_n,
    input wire logic global_enable_n,
    // channels
    input wire logic [CHANNELS-1:0] gate_cmd,
    input wire logic [CHANNELS-1:0] parallel_gate_in,
    input wire logic [CHANNELS-1:0] gate_drive_out,
    input wire logic [CHANNELS-1:0] fault_latched,
    // status
    input wire logic fault_flag_n_oe,
    input wire logic serial_enable,
    input wire logic timer_clock_enable,
    input wire logic diag_enable,
    input wire logic clear_config,
    input wire logic send_revision,
    input wire logic ready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // init must finish well inside this bound
    sequence s_release; $rose(master_reset_n) && logic_supply; endsequence
    sequence s_up; serial_enable && ready; endsequence
    property p_sup_off; !logic_supply |=> gate_drive_out == 0 && !fault_flag_n_oe; endproperty
    a_sup_off: assert property (p_sup_off) else $error("gates or flag on at low supply");
    property p_sup_clr; !logic_supply |=> clear_config && fault_latched == 0; endproperty
    a_sup_clr: assert property (p_sup_clr) else $error("state kept at low supply");
    property p_rst_off;
        !master_reset_n |=> gate_drive_out == 0 && !serial_enable && !timer_clock_enable
            && !fault_flag_n_oe;
    endproperty
    a_rst_off: assert property (p_rst_off) else $error("output on in reset");
    property p_rst_clr; !master_reset_n |=> clear_config && fault_latched == 0; endproperty
    a_rst_clr: assert property (p_rst_clr) else $error("state kept in reset");
    property p_rel; s_release |-> ##[1:24] s_up; endproperty
    a_rel: assert property (p_rel) else $error("no restart after reset");
    property p_dis; global_enable_n |=> gate_drive_out == 0 && !diag_enable; endproperty
    a_dis: assert property (p_dis) else $error("gates on while disabled");
    property p_spi; ready && global_enable_n |-> serial_enable; endproperty
    a_spi: assert property (p_spi) else $error("serial off while disabled");
    property p_keep;
        ready && global_enable_n && master_reset_n && logic_supply |=> $stable(fault_latched);
    endproperty
    a_keep: assert property (p_keep) else $error("fault data lost");
    property p_cause;
        gate_drive_out != 0 |-> ready && !$past(global_enable_n) && $past(master_reset_n)
            && $past(logic_supply)
            && (gate_drive_out & ~($past(gate_cmd) | $past(parallel_gate_in))) == 0;
    endproperty
    a_cause: assert property (p_cause) else $error("gate on without cause");
    property p_rev; !master_reset_n |=> send_revision; endproperty
    a_rev: assert property (p_rev) else $error("revision not pending");
endmodule // reset_enable_checker
bind predriver_reset_enable_control reset_enable_checker #(.CHANNELS(CHANNELS),
    .RETRY_CYCLES(RETRY_CYCLES)) checker_i (
    .clk(clk), .reset(reset), .logic_supply(logic_supply),
    .master_reset_n(master_reset_n), .global_enable_n(global_enable_n),
    .gate_cmd(gate_cmd), .parallel_gate_in(parallel_gate_in),
    .gate_drive_out(gate_drive_out), .fault_latched(fault_latched),
    .fault_flag_n_oe(fault_flag_n_oe), .serial_enable(serial_enable),
    .timer_clock_enable(timer_clock_enable), .diag_enable(diag_enable),
    .clear_config(clear_config), .send_revision(send_revision), .ready(ready));
`default_nettype wire

// file: verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // frame control
    input wire logic clk,
    input wire logic go,
    output logic chip_select_n
);
    int len = 0;
    int gap = 200;
    initial chip_select_n = 1'b1;
    // 16-cycle frames; go is ignored until the 200-cycle gap has ended
    always @(posedge clk) begin
        if (len > 0) begin
            len <= len - 1;
            if (len == 1) chip_select_n <= 1'b1;
        end else if (gap < 200) gap <= gap + 1;
        else if (go) begin
            chip_select_n <= 1'b0;
            len <= 16;
            gap <= 0;
        end
    end
endmodule // host_model
`default_nettype wire

// file: verif/predriver_reset_enable_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module predriver_reset_enable_control_tb_top;
    logic clk = 1'b0, reset = 1'b1, logic_supply = 1'b1, master_reset_n = 1'b1;
    logic global_enable_n = 1'b0, go = 1'b0;
    logic [5:0] gate_cmd = 6'h00, parallel_gate_in = 6'h00, fault_detect = 6'h00;
    logic [5:0] retry_mode = 6'h00;
    wire logic [5:0] gate_drive_out, fault_latched;
    wire logic chip_select_n, fault_flag_n_oe, serial_enable, timer_clock_enable;
    wire logic diag_enable, clear_config, send_revision, ready;
    int num_errors = 0, checks = 0, cycles = 0;
    always #4 clk = ~clk;
    predriver_reset_enable_control #(.RETRY_CYCLES(20)) predriver_reset_enable_control_i (
        .clk(clk), .reset(reset), .logic_supply(logic_supply), .master_reset_n(master_reset_n),
        .global_enable_n(global_enable_n), .chip_select_n(chip_select_n), .gate_cmd(gate_cmd),
        .parallel_gate_in(parallel_gate_in), .retry_mode(retry_mode), .fault_detect(fault_detect),
        .gate_drive_out(gate_drive_out), .fault_latched(fault_latched),
        .fault_flag_n_oe(fault_flag_n_oe), .fault_flag_n_out(), .serial_enable(serial_enable),
        .timer_clock_enable(timer_clock_enable), .diag_enable(diag_enable),
        .clear_config(clear_config), .send_revision(send_revision), .ready(ready));
    host_model host_model_i (.clk(clk), .go(go), .chip_select_n(chip_select_n));
    // ----
    // helpers: inputs move only at falling edges
    // ----
    task step(input int n); repeat (n) @(negedge clk); endtask
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task up;
        for (int i = 0; i < 40 && ready !== 1'b1; i++) step(1);
        step(2);
    endtask
    task conclude;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ----
    // scenarios
    // ----
    task t_boot;
        up();
        gate_cmd = 6'h15;
        parallel_gate_in = 6'h02;
        step(2);
        chk({2'h0, gate_drive_out}, 8'h17);
        chk(8'({ready, serial_enable, send_revision, clear_config}), 8'h0e);
        chk(8'({timer_clock_enable, diag_enable, fault_flag_n_oe}), 8'h06);
        go = 1'b1;
        step(1);
        go = 1'b0;
        step(24);
        chk(8'(send_revision), 8'h00);
        $display("boot done");
    endtask
    task t_fault;
        global_enable_n = 1'b1;
        step(2);
        chk({2'h0, gate_drive_out}, 8'h00);
        chk(8'({serial_enable, diag_enable}), 8'h02);
        global_enable_n = 1'b0;
        step(2);
        fault_detect = 6'h04;
        step(1);
        fault_detect = 6'h00;
        step(2);
        chk({fault_flag_n_oe, 1'b0, gate_drive_out}, 8'h93);
        step(22);
        chk({2'h0, gate_drive_out}, 8'h13);
        global_enable_n = 1'b1;
        step(2);
        chk({2'h0, fault_latched}, 8'h04);
        global_enable_n = 1'b0;
        step(2);
        chk({2'h0, gate_drive_out}, 8'h17);
        $display("enable and fault done");
    endtask
    task t_retry;
        retry_mode = 6'h01;
        fault_detect = 6'h01;
        step(1);
        fault_detect = 6'h00;
        step(1);
        chk({2'h0, gate_drive_out}, 8'h16);
        step(22);
        chk({2'h0, gate_drive_out}, 8'h17);
        chk({2'h0, fault_latched}, 8'h05);
        retry_mode = 6'h00;
        $display("retry done");
    endtask
    task t_resets;
        master_reset_n = 1'b0;
        step(2);
        chk({2'h0, gate_drive_out}, 8'h00);
        chk(8'({serial_enable, timer_clock_enable, fault_flag_n_oe}), 8'h00);
        chk({fault_latched, clear_config, send_revision}, 8'h03);
        master_reset_n = 1'b1;
        up();
        chk(8'({serial_enable, send_revision, clear_config}), 8'h06);
        logic_supply = 1'b0;
        step(2);
        chk({2'h0, gate_drive_out}, 8'h00);
        chk(8'({fault_flag_n_oe, clear_config, ready}), 8'h02);
        logic_supply = 1'b1;
        up();
        chk({2'h0, gate_drive_out}, 8'h17);
        $display("resets done");
    endtask
    // cycle ceiling far above the roughly 160 cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        step(8);
        reset = 1'b0;
        t_boot();
        t_fault();
        t_retry();
        t_resets();
        conclude();
    end
endmodule // predriver_reset_enable_control_tb_top
`default_nettype wire
